/* include/bcr_pkg.sv */
/*
  shared constants and types for the calendar clock register block.
  assumes a 32-bit apb slave at pclk, offsets are byte addresses.
*/
package bcr_pkg;
  // register bases
  localparam logic [11:0] OFF_CLOCK_CONTROL = 12'h200;
  localparam logic [11:0] OFF_ALARM_CONTROL = 12'h210;
  localparam logic [11:0] OFF_TIME_VALUE    = 12'h220;
  localparam logic [11:0] OFF_DATE_VALUE    = 12'h230;
  localparam logic [11:0] OFF_ALARM_TIME    = 12'h240;
  localparam logic [11:0] OFF_ALARM_DATE    = 12'h250;
  localparam logic [11:0] OFF_IRQ_STATUS    = 12'h260;
  localparam logic [11:0] OFF_IRQ_MASK      = 12'h270;
  // alias sub-offsets
  localparam logic [1:0]  ALIAS_PLAIN       = 2'h0;
  localparam logic [1:0]  ALIAS_CLEAR       = 2'h1;
  localparam logic [1:0]  ALIAS_SET         = 2'h2;
  localparam logic [1:0]  ALIAS_TOGGLE      = 2'h3;
  // implemented-bit masks, unlock bit index and reset values
  localparam logic [31:0] MASK_CLOCK_CONTROL = 32'h03ff_a0cf;
  localparam logic [31:0] MASK_ALARM_CONTROL = 32'h0000_ffff;
  localparam logic [31:0] MASK_TIME          = 32'h3f7f_7f00;
  localparam logic [31:0] MASK_DATE          = 32'hff1f_3f07;
  localparam logic [31:0] MASK_ALARM_DATE    = 32'h001f_ff07;
  localparam logic [31:0] MASK_IRQ           = 32'h0000_0003;
  localparam int          UNLOCK_BIT         = 3;
  localparam logic [31:0] RESET_CONTROL      = 32'h0000_0000;
  localparam logic [31:0] RESET_IRQ          = 32'h0000_0000;
  // irq bits, value word count and value reset index
  localparam int          IRQ_DATE_WRITTEN   = 0;
  localparam int          IRQ_DATE_REFUSED   = 1;
  localparam int          NUM_VALUES         = 4;
  localparam logic [9:0]  RESET_VAL_INDEX    = 10'h000;

  typedef struct packed {
    logic [3:0] year_tens_digit;
    logic [3:0] year_units_digit;
    logic [2:0] pad_a;
    logic       month_tens_digit;
    logic [3:0] month_units_digit;
    logic [1:0] pad_b;
    logic [1:0] day_tens_digit;
    logic [3:0] day_units_digit;
    logic [4:0] pad_c;
    logic [2:0] weekday_number;
  } bcr_date_t;

  typedef struct packed {
    logic        wr;
    logic [1:0]  idx;
    logic [31:0] data;
  } bcr_mem_wr_t;
endpackage

/* src/bcr_alias_calc.sv */
/*
  applies plain, clear, set or toggle alias writes to a word.
  masks unimplemented bits itself with the mask input.
*/
module bcr_alias_calc
  import bcr_pkg::*;
(
  // inputs
  input  wire logic [31:0] cur,
  input  wire logic [31:0] wdata,
  input  wire logic [1:0]  kind,
  input  wire logic [31:0] mask,
  // result
  output logic      [31:0] result
);
  // clear, set, toggle: one-bits of wdata select which bits change; plain writes wdata whole
  always_comb begin
    unique case (kind)
      ALIAS_CLEAR:  result = cur & ~wdata & mask;
      ALIAS_SET:    result = (cur | wdata) & mask;
      ALIAS_TOGGLE: result = (cur ^ wdata) & mask;
      default:      result = wdata & mask;
    endcase
  end
endmodule

/* src/bcr_value_mem.sv */
/*
  small storage of the four bcd value words, registered read port.
  assumes one write and one read address per cycle; no reset on content.
*/
module bcr_value_mem
  import bcr_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // write side
  input  wire bcr_mem_wr_t wr,
  // read side
  input  wire logic [1:0]  raddr,
  output logic      [31:0] rdata
);
  logic [31:0] store [NUM_VALUES];

  // contents left undefined at reset on purpose
  always_ff @(posedge pclk) begin
    if (wr.wr) begin
      store[wr.idx] <= wr.data;
    end
  end

  always_ff @(posedge pclk) begin
    rdata <= store[raddr];
  end
endmodule

/* src/bcr_top.sv */
/*
  apb register block of a bcd calendar clock: control, alarm control,
  time, date and alarm values with clear/set/toggle aliases, plus irq.
  assumes an apb master on pclk; counting logic lives elsewhere.
*/
// Notes on behaviour
// - date bits 31:28 hold year tens digit, bcd 0..9.
// - date bits 27:24 hold year units digit, bcd 0..9.
// - date bit 20 holds month tens digit, 0 or 1.
// - date bits 19:16 hold month units digit, bcd 0..9.
// - date bits 13:12 hold day tens digit, 0..3.
// - date bits 11:8 hold day units digit, bcd 0..9.
// - date bits 2:0 hold weekday number, 0..6.
// - date writes ignored unless control bit 3 unlock is set.
// - each register has clear, set, toggle aliases at +4, +8, +c.
// - unimplemented bits read zero and ignore writes.
// - control and alarm control reset to zero; value digits undefined.
module bcr_top
  import bcr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // block outputs
  output logic             irq,
  output logic             calendar_write_unlock,
  output logic      [31:0] clock_control,
  output logic      [31:0] alarm_control
);
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [1:0]  alias_kind;
  logic [11:0] base;
  logic        setup;
  logic        access;
  logic        phase2;
  logic        is_value;
  logic [1:0]  vidx;
  logic        mapped;
  logic [31:0] cur_word;
  logic [31:0] cur_mask;
  logic [31:0] new_word;
  logic [31:0] mem_rdata;
  logic        date_wr_try;
  bcr_mem_wr_t mem_wr;
  logic [31:0] held_sel;
  logic        rd_from_mem;

  // address split: low nibble picks the alias
  assign base       = {paddr[11:4], 4'h0};
  assign alias_kind = paddr[3:2];
  assign setup      = psel & ~penable;
  assign access     = psel & penable & phase2;
  assign is_value   = (base >= OFF_TIME_VALUE) && (base <= OFF_ALARM_DATE);
  assign vidx       = 2'(base[5:4] - 2'h2);

  // decode base word and implemented mask
  always_comb begin
    mapped   = 1'b1;
    cur_word = 32'h0000_0000;
    cur_mask = 32'h0000_0000;
    unique case (base)
      OFF_CLOCK_CONTROL: begin
        cur_word = clock_control;
        cur_mask = MASK_CLOCK_CONTROL;
      end
      OFF_ALARM_CONTROL: begin
        cur_word = alarm_control;
        cur_mask = MASK_ALARM_CONTROL;
      end
      OFF_TIME_VALUE, OFF_ALARM_TIME: begin
        cur_word = mem_rdata;
        cur_mask = MASK_TIME;
      end
      OFF_DATE_VALUE: begin
        cur_word = mem_rdata;
        cur_mask = MASK_DATE;
      end
      OFF_ALARM_DATE: begin
        cur_word = mem_rdata;
        cur_mask = MASK_ALARM_DATE;
      end
      OFF_IRQ_STATUS: begin
        cur_word = irq_status;
        cur_mask = MASK_IRQ;
      end
      OFF_IRQ_MASK: begin
        cur_word = irq_mask;
        cur_mask = MASK_IRQ;
      end
      default: mapped = 1'b0;
    endcase
  end

  bcr_alias_calc u_alias (
    .cur    (cur_word),
    .wdata  (pwdata),
    .kind   (alias_kind),
    .mask   (cur_mask),
    .result (new_word)
  );

  // two-cycle access: memory read data lands during the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase2 <= 1'b0;
    end else begin
      phase2 <= psel & penable & ~phase2;
    end
  end

  assign date_wr_try = access & pwrite & (base == OFF_DATE_VALUE);

  // value memory write port, date gated by unlock
  always_comb begin
    mem_wr.wr   = access & pwrite & is_value &
                  ((base != OFF_DATE_VALUE) | clock_control[UNLOCK_BIT]);
    mem_wr.idx  = vidx;
    mem_wr.data = new_word;
  end

  bcr_value_mem u_mem (
    .pclk  (pclk),
    .wr    (mem_wr),
    .raddr (vidx),
    .rdata (mem_rdata)
  );

  // control registers clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_control <= RESET_CONTROL;
      alarm_control <= RESET_CONTROL;
    end else if (access & pwrite) begin
      if (base == OFF_CLOCK_CONTROL) begin
        clock_control <= new_word;
      end
      if (base == OFF_ALARM_CONTROL) begin
        alarm_control <= new_word;
      end
    end
  end

  assign calendar_write_unlock = clock_control[UNLOCK_BIT];

  // sticky events: set beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RESET_IRQ;
      irq_mask   <= RESET_IRQ;
    end else begin
      if (access & pwrite & (base == OFF_IRQ_STATUS) & (alias_kind == ALIAS_PLAIN)) begin
        irq_status <= (irq_status & ~pwdata & MASK_IRQ) | held_sel;
      end else if (access & pwrite & (base == OFF_IRQ_STATUS)) begin
        irq_status <= new_word | held_sel;
      end else begin
        irq_status <= irq_status | held_sel;
      end
      if (access & pwrite & (base == OFF_IRQ_MASK)) begin
        irq_mask <= new_word;
      end
    end
  end

  // events raised by date writes, accepted or refused
  always_comb begin
    held_sel = 32'h0000_0000;
    held_sel[IRQ_DATE_WRITTEN] = date_wr_try & clock_control[UNLOCK_BIT];
    held_sel[IRQ_DATE_REFUSED] = date_wr_try & ~clock_control[UNLOCK_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  assign rd_from_mem = is_value;

  // apb answer on second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~phase2 & ~pready;
      pslverr <= psel & penable & ~phase2 & ~pready & ~mapped;
      if (psel & penable & ~phase2 & ~pwrite) begin
        prdata <= (rd_from_mem ? mem_rdata : cur_word) & cur_mask;
      end
    end
  end

  // bounded answer time
  property p_ready_two;
    @(posedge pclk) disable iff (!presetn)
      (setup ##1 (psel & penable)) |-> ##1 pready;
  endproperty
  a_ready_two: assert property (p_ready_two) else $error("pready late");

  property p_date_lock;
    @(posedge pclk) disable iff (!presetn)
      (mem_wr.wr & (mem_wr.idx == 2'h1)) |-> clock_control[UNLOCK_BIT];
  endproperty
  a_date_lock: assert property (p_date_lock) else $error("date written while locked");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      $rose(pready) & ~pwrite & (base == OFF_DATE_VALUE) |-> ((prdata & ~MASK_DATE) == 32'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved date bits set");

  property p_ctl_reset;
    @(posedge pclk) $rose(presetn) |-> (clock_control == 32'h0) && (alarm_control == 32'h0);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control not cleared");

  property p_set_alias;
    @(posedge pclk) disable iff (!presetn)
      (access & pwrite & (base == OFF_CLOCK_CONTROL) & (alias_kind == ALIAS_SET))
        |=> ((clock_control & $past(pwdata) & MASK_CLOCK_CONTROL) == ($past(pwdata) & MASK_CLOCK_CONTROL));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias failed");

  property p_clr_alias;
    @(posedge pclk) disable iff (!presetn)
      (access & pwrite & (base == OFF_ALARM_CONTROL) & (alias_kind == ALIAS_CLEAR))
        |=> ((alarm_control & $past(pwdata)) == 32'h0);
  endproperty
  a_clr_alias: assert property (p_clr_alias) else $error("clear alias failed");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (|(irq_status & irq_mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");

  property p_ctl_mask;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> ((clock_control & ~MASK_CLOCK_CONTROL) == 32'h0);
  endproperty
  a_ctl_mask: assert property (p_ctl_mask) else $error("unimplemented control bit set");

  property p_irq_low;
    @(posedge pclk) disable iff (!presetn)
      !(|(irq_status & irq_mask)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq stuck high");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

  property p_date_evt_ok;
    @(posedge pclk) disable iff (!presetn)
      (date_wr_try & clock_control[UNLOCK_BIT]) |=> irq_status[IRQ_DATE_WRITTEN];
  endproperty
  a_date_evt_ok: assert property (p_date_evt_ok) else $error("accepted date write not flagged");

  property p_date_evt_refused;
    @(posedge pclk) disable iff (!presetn)
      (date_wr_try & ~clock_control[UNLOCK_BIT]) |=> irq_status[IRQ_DATE_REFUSED];
  endproperty
  a_date_evt_refused: assert property (p_date_evt_refused) else $error("refused date write not flagged");

  property p_alarm_mask;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> ((alarm_control & ~MASK_ALARM_CONTROL) == 32'h0);
  endproperty
  a_alarm_mask: assert property (p_alarm_mask) else $error("unimplemented alarm bit set");

  property p_tgl_alias;
    @(posedge pclk) disable iff (!presetn)
      (access & pwrite & (base == OFF_CLOCK_CONTROL) & (alias_kind == ALIAS_TOGGLE))
        |=> (clock_control == (($past(clock_control) ^ $past(pwdata)) & MASK_CLOCK_CONTROL));
  endproperty
  a_tgl_alias: assert property (p_tgl_alias) else $error("toggle alias failed");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      $rose(pready) |-> (pslverr == ~mapped);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("pslverr does not match decode");

  property p_date_store_mask;
    @(posedge pclk) disable iff (!presetn)
      (mem_wr.wr & (mem_wr.idx == 2'h1)) |-> ((mem_wr.data & ~MASK_DATE) == 32'h0);
  endproperty
  a_date_store_mask: assert property (p_date_store_mask) else $error("unimplemented date bit stored");
endmodule

/* tb/bcr_top_tb_top.sv */
/*
  self-checking bench for the calendar clock register block.
  assumes the block answers apb requests on pclk and raises pready itself.
*/
module bcr_top_tb_top
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } bcr_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic        calendar_write_unlock;
  logic [31:0] clock_control;
  logic [31:0] alarm_control;
  int          err_count;
  int          checks_done;
  logic [31:0] r;
  logic        e;
  bcr_row_t    rows [14];

  bcr_top dut (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .irq                   (irq),
    .calendar_write_unlock (calendar_write_unlock),
    .clock_control         (clock_control),
    .alarm_control         (alarm_control)
  );

  // 50 mhz clock
  always #10 pclk = ~pclk;

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
    chk1(y, 1'b0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, a, 32'h0000_0000, x, y);
    chk1(y, 1'b0);
    chk32(x, exp);
  endtask

  // write, then read back the plain register of each row
  initial begin
    rows[0] = '{OFF_CLOCK_CONTROL, 32'hffff_ffff, 32'h03ff_a0cf};
    rows[1] = '{OFF_DATE_VALUE, 32'h9812_3106, 32'h9812_3106};
    rows[2] = '{OFF_DATE_VALUE, 32'hffff_ffff, 32'hff1f_3f07};
    rows[3] = '{OFF_DATE_VALUE + 12'h004, 32'h0f00_0000, 32'hf01f_3f07};
    rows[4] = '{OFF_DATE_VALUE + 12'h008, 32'h0100_0000, 32'hf11f_3f07};
    rows[5] = '{OFF_DATE_VALUE + 12'h00c, 32'hff00_0000, 32'h0e1f_3f07};
    rows[6] = '{OFF_TIME_VALUE, 32'hffff_ffff, 32'h3f7f_7f00};
    rows[7] = '{OFF_ALARM_TIME, 32'h1234_5600, 32'h1234_5600};
    rows[8] = '{OFF_ALARM_DATE, 32'hffff_ffff, 32'h001f_ff07};
    rows[9] = '{OFF_ALARM_CONTROL, 32'hffff_ffff, 32'h0000_ffff};
    // alias writes on the control side; unlock bit 3 stays set throughout
    rows[10] = '{OFF_CLOCK_CONTROL + 12'h004, 32'h0300_0000, 32'h00ff_a0cf};
    rows[11] = '{OFF_CLOCK_CONTROL + 12'h008, 32'h0100_0000, 32'h01ff_a0cf};
    rows[12] = '{OFF_ALARM_CONTROL + 12'h004, 32'h0000_00f0, 32'h0000_ff0f};
    rows[13] = '{OFF_CLOCK_CONTROL + 12'h00c, 32'h0000_0040, 32'h01ff_a08f};
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk32(clock_control, RESET_CONTROL);
    rd_chk(OFF_CLOCK_CONTROL, 32'h0000_0000);
    rd_chk(OFF_ALARM_CONTROL, 32'h0000_0000);
    chk1(irq, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a & 12'hff0, rows[i].e);
    end
    chk32(alarm_control, 32'h0000_ff0f);
    // locked date ignores plain and alias writes
    wr(OFF_CLOCK_CONTROL + 12'h004, 32'h0000_0008);
    // the register changes at the write edge itself, so look one edge later
    @(posedge pclk);
    chk1(calendar_write_unlock, 1'b0);
    wr(OFF_DATE_VALUE, 32'h0000_0000);
    wr(OFF_DATE_VALUE + 12'h008, 32'hffff_ffff);
    rd_chk(OFF_DATE_VALUE, 32'h0e1f_3f07);
    // unmapped place answers with an error
    apb(1'b0, 12'h300, 32'h0000_0000, r, e);
    chk1(e, 1'b1);
    // interrupt: raised, masked, cleared
    rd_chk(OFF_IRQ_STATUS, 32'h0000_0003);
    chk1(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk1(irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk1(irq, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 32'h0000_0001);
    // second reset in mid-run clears the control side again
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk32(clock_control, RESET_CONTROL);
    chk32(alarm_control, 32'h0000_0000);
    chk1(calendar_write_unlock, 1'b0);
    rd_chk(OFF_IRQ_STATUS, RESET_IRQ);
    give_verdict();
  end
endmodule
